// ### common/sf_defs.svh
// Purpose: constants for the serial flash status and protection decoder
// Assumes: included by bare name; sf_pkg holds the types
// Notes: opcodes, status field positions, bit counts
//
// What this block does
// (RULE_01) status bit 0 reads 1 while program or erase runs, read-only
// (RULE_02) while busy only status read is served; master issues nothing else
// (RULE_03) status bit 1 shows write enable latch; latch 0 rejects writes
// (RULE_04) latch clears at power-up and after disable, program, erase, status write
// (RULE_05) master sends write enable before every erase, program or status write
// (RULE_06) bottom-select 0, levels 001/010/011 protect top eighth/quarter/half
// (RULE_07) bottom-select 1, levels 001/010/011 protect bottom eighth/quarter/half
// (RULE_08) top level bit protects everything; all levels zero protect nothing
// (RULE_09) program or erase into the protected region is refused
// (RULE_10) chip erase runs only when all protect level bits are zero
// (RULE_11) write-protect pin low with lock set freezes levels, bottom-select, lock
// (RULE_12) write-protect pin high ignores lock; status write updates freely
// (RULE_13) levels, bottom-select and lock are non-volatile, reloaded at power-up
// (RULE_14) status bit 6 is reserved and reads 0
// (RULE_15) every bus cycle is 8 bits, MSB first, sampled on rising clock
// (RULE_16) instructions start at select fall; non-reads end at select rise
// (RULE_17) select rising mid bus cycle abandons the instruction
// (RULE_18) 03 reads after 3 address bytes; 0B adds one dummy byte
// (RULE_19) 3B outputs on two lines; BB also takes address and dummy on two
// (RULE_20) 20/D7 sector, D8 block erase after address; 60/C7 chip erase
// (RULE_21) 02 programs from 3 address bytes and 1 to 256 data bytes
// (RULE_22) decode 05, 01, 06, 04, B9, AB and 9F as listed
// (RULE_23) both clock idle levels work: sample on rise, drive after fall
// (RULE_24) status write refused when write-protect pin low and lock set
`ifndef SF_DEFS_SVH
`define SF_DEFS_SVH
`define SF_OPC_READ 8'h03
`define SF_OPC_FAST 8'h0B
`define SF_OPC_DUAL_OUT 8'h3B
`define SF_OPC_DUAL_IO 8'hBB
`define SF_OPC_SECT 8'h20
`define SF_OPC_SECT_ALT 8'hD7
`define SF_OPC_BLOCK 8'hD8
`define SF_OPC_CHIP 8'h60
`define SF_OPC_CHIP_ALT 8'hC7
`define SF_OPC_PROG 8'h02
`define SF_OPC_STAT_RD 8'h05
`define SF_OPC_STAT_WR 8'h01
`define SF_OPC_WEN 8'h06
`define SF_OPC_WDIS 8'h04
`define SF_OPC_SLEEP 8'hB9
`define SF_OPC_ID_WAKE 8'hAB
`define SF_OPC_ID_STD 8'h9F
`define SF_ST_BUSY 0
`define SF_ST_WRITE_EN 1
`define SF_ST_LEVEL_LO 2
`define SF_ST_LEVEL_HI 4
`define SF_ST_BOTTOM 5
`define SF_ST_RSVD 6
`define SF_ST_LOCK 7
`define SF_BYTE_BITS 6'h08
`define SF_ADDR_BITS 6'h18
`define SF_PAGE_MAX 9'h100
`define SF_STATUS_RST 8'h00
`endif

// ### common/sf_pkg.sv
// Purpose: types shared by the serial flash decoder and its users
// Assumes: constants live in sf_defs.svh
// Notes: array_op_s is handed to the program/erase sequencer
package sf_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_OPCODE = 3'b001, ST_ADDR = 3'b010, ST_DUMMY = 3'b011,
		ST_DATA_IN = 3'b100, ST_DATA_OUT = 3'b101, ST_DONE = 3'b110, ST_IGNORE = 3'b111
	} link_state_e;
	typedef enum logic [1:0] {
		OP_SECTOR_ERASE = 2'b00, OP_BLOCK_ERASE = 2'b01, OP_CHIP_ERASE = 2'b10, OP_PROGRAM = 2'b11
	} array_op_e;
	typedef struct packed {
		array_op_e kind;
		logic [23:0] addr;
		logic [8:0] count;
	} array_op_s;
endpackage : sf_pkg

// ### logic/serial_flash_status_protect_decode.sv
// Purpose: instruction decoder, status register and block protection of a serial flash
// Assumes: link pins sampled by i_core_clk; array, page buffer reader and nv store on i_core_clk
// Notes: instructions execute at select release; reads stream until select release
`timescale 1ns/1ps
`default_nettype none
`include "sf_defs.svh"

module serial_flash_status_protect_decode
	import sf_pkg::*;
#(
	// identification bytes: values are arbitrary
	parameter logic [7:0] ID_MAKER = 8'hA5,
	parameter logic [7:0] ID_TYPE = 8'h3C,
	parameter logic [7:0] ID_SIZE = 8'h13,
	parameter logic [7:0] ID_PART = 8'h7E
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	// serial link pins
	input wire logic i_cs_b,
	input wire logic i_sck,
	input wire logic i_sio0,
	input wire logic i_sio1,
	input wire logic i_wp_b,
	output var logic o_sio0,
	output var logic o_sio0_oe,
	output var logic o_sio1,
	output var logic o_sio1_oe,
	// array read port
	output var logic [23:0] o_rd_addr,
	input wire logic [7:0] i_rd_data,
	// program and erase sequencer
	output var array_op_s o_op,
	output var logic o_op_valid,
	input wire logic i_seq_done,
	input wire logic [7:0] i_pbuf_idx,
	output var logic [7:0] o_pbuf_data,
	// non-volatile status store
	input wire logic [7:0] i_nv_status,
	output var logic o_nv_write,
	output var logic [7:0] o_nv_value,
	// status view
	output var logic [7:0] o_status,
	output var logic o_deep_sleep
);

	function automatic link_state_e opc_decode(input logic [7:0] opc, input logic busy, input logic asleep);
		link_state_e s;
		begin
			s = ST_IGNORE;
			if (busy) begin
				if (opc == `SF_OPC_STAT_RD) s = ST_DATA_OUT; // RULE_02
			end else if (asleep) begin
				if (opc == `SF_OPC_ID_WAKE) s = ST_ADDR;
			end else begin
				case (opc)
					`SF_OPC_READ, `SF_OPC_FAST, `SF_OPC_DUAL_OUT, `SF_OPC_DUAL_IO: s = ST_ADDR; // RULE_18 RULE_19
					`SF_OPC_SECT, `SF_OPC_SECT_ALT, `SF_OPC_BLOCK, `SF_OPC_PROG: s = ST_ADDR; // RULE_20 RULE_21
					`SF_OPC_ID_WAKE: s = ST_ADDR; // RULE_22
					`SF_OPC_STAT_RD, `SF_OPC_ID_STD: s = ST_DATA_OUT; // RULE_22
					`SF_OPC_STAT_WR: s = ST_DATA_IN; // RULE_22
					`SF_OPC_WEN, `SF_OPC_WDIS, `SF_OPC_SLEEP: s = ST_DONE; // RULE_22
					`SF_OPC_CHIP, `SF_OPC_CHIP_ALT: s = ST_DONE; // RULE_20
					default: s = ST_IGNORE;
				endcase
			end
			opc_decode = s;
		end
	endfunction : opc_decode

	// a seen from the protected end: 111 means the outermost eighth
	function automatic logic addr_prot(input logic [23:0] a, input logic [2:0] lv, input logic bot);
		logic [2:0] hi;
		begin
			hi = bot ? ~a[18:16] : a[18:16]; // RULE_06 RULE_07
			if (lv[2]) addr_prot = 1'b1; // RULE_08
			else if (lv == 3'h1) addr_prot = &hi;
			else if (lv == 3'h2) addr_prot = &hi[2:1];
			else if (lv == 3'h3) addr_prot = hi[2];
			else addr_prot = 1'b0; // RULE_08
		end
	endfunction : addr_prot

	logic [4:0] sync1_reg, sync2_reg;
	logic sck_prev_reg, cs_prev_reg;
	link_state_e state_reg, state_next, opc_next_st, addr_next_st;
	logic [7:0] op_reg, sw_data_reg, out_reg, widx_reg;
	logic [5:0] cnt_reg;
	logic [31:0] shift_reg;
	logic [23:0] addr_reg;
	logic [8:0] byte_cnt_reg;
	logic [3:0] out_left_reg;
	logic [1:0] id_idx_reg;
	logic wel_reg, busy_reg, bottom_reg, lock_reg, loaded_reg;
	logic [2:0] bp_reg;
	logic [7:0] pbuf [0:255];

	// pin view after two flops
	wire cs_b_s = sync2_reg[4];
	wire sck_s = sync2_reg[3];
	wire sio0_s = sync2_reg[2];
	wire sio1_s = sync2_reg[1];
	wire wp_b_s = sync2_reg[0];
	wire sck_rise = sck_s & ~sck_prev_reg & ~cs_b_s; // RULE_15 RULE_23
	wire sck_fall = ~sck_s & sck_prev_reg & ~cs_b_s; // RULE_23
	wire cs_fall = ~cs_b_s & cs_prev_reg; // RULE_16
	wire cs_rise = cs_b_s & ~cs_prev_reg;

	// input shifting, one or two bits per rising edge
	wire dual_in = (op_reg == `SF_OPC_DUAL_IO) && (state_reg == ST_ADDR || state_reg == ST_DUMMY); // RULE_19
	wire dual_out = (op_reg == `SF_OPC_DUAL_OUT) || (op_reg == `SF_OPC_DUAL_IO); // RULE_19
	wire [5:0] cnt_inc = cnt_reg + (dual_in ? 6'h02 : 6'h01);
	wire [31:0] shift_in = dual_in ? {shift_reg[29:0], sio1_s, sio0_s} : {shift_reg[30:0], sio0_s}; // RULE_15
	wire in_phase = state_reg == ST_OPCODE || state_reg == ST_ADDR || state_reg == ST_DUMMY ||
		state_reg == ST_DATA_IN;
	wire phase_end = sck_rise && in_phase &&
		(cnt_inc == ((state_reg == ST_ADDR) ? `SF_ADDR_BITS : `SF_BYTE_BITS)); // RULE_15
	assign opc_next_st = opc_decode(shift_in[7:0], busy_reg, o_deep_sleep);
	assign addr_next_st = (op_reg == `SF_OPC_FAST || dual_out) ? ST_DUMMY : // RULE_18 RULE_19
		(op_reg == `SF_OPC_READ || op_reg == `SF_OPC_ID_WAKE) ? ST_DATA_OUT :
		(op_reg == `SF_OPC_PROG) ? ST_DATA_IN : ST_DONE;

	// command classes and execution at select release
	wire is_sect = op_reg == `SF_OPC_SECT || op_reg == `SF_OPC_SECT_ALT;
	wire is_block = op_reg == `SF_OPC_BLOCK;
	wire is_chip = op_reg == `SF_OPC_CHIP || op_reg == `SF_OPC_CHIP_ALT;
	wire is_prog = op_reg == `SF_OPC_PROG;
	wire is_stat_wr = op_reg == `SF_OPC_STAT_WR;
	wire target_prot = addr_prot(addr_reg, bp_reg, bottom_reg);
	wire exec_ok = cs_rise && (state_reg == ST_DONE || // RULE_16 RULE_17
		(state_reg == ST_DATA_IN && is_prog && cnt_reg == 6'h00 && byte_cnt_reg != 9'h000));
	wire issue = exec_ok && wel_reg && // RULE_03
		((is_chip && bp_reg == 3'h0) || ((is_sect || is_block || is_prog) && !target_prot)); // RULE_09 RULE_10
	wire wel_clr = exec_ok && (op_reg == `SF_OPC_WDIS || is_sect || is_block || is_chip || is_prog || is_stat_wr);
	wire wel_set = exec_ok && op_reg == `SF_OPC_WEN;
	wire locked = !wp_b_s && lock_reg; // RULE_11 RULE_12
	wire sw_ok = exec_ok && is_stat_wr && wel_reg && !locked; // RULE_03 RULE_24
	wire wake = cs_rise && state_reg == ST_ADDR && op_reg == `SF_OPC_ID_WAKE && cnt_reg == 6'h00;
	wire [7:0] status_byte = {lock_reg, 1'b0, bottom_reg, bp_reg, wel_reg, busy_reg}; // RULE_01 RULE_14
	wire array_op_e op_kind = is_chip ? OP_CHIP_ERASE : is_block ? OP_BLOCK_ERASE :
		is_prog ? OP_PROGRAM : OP_SECTOR_ERASE;

	// output serialiser, loads a fresh byte when the last one is spent
	wire [7:0] id_byte = (id_idx_reg == 2'h0) ? ID_MAKER : (id_idx_reg == 2'h1) ? ID_TYPE : ID_SIZE;
	wire [7:0] src_byte = (op_reg == `SF_OPC_STAT_RD) ? status_byte :
		(op_reg == `SF_OPC_ID_STD) ? id_byte : (op_reg == `SF_OPC_ID_WAKE) ? ID_PART : i_rd_data;
	wire out_load = out_left_reg == 4'h0;
	wire [7:0] out_word = out_load ? src_byte : out_reg;
	wire [3:0] out_left_base = out_load ? 4'h8 : out_left_reg;
	wire [3:0] out_left_next = out_left_base - (dual_out ? 4'h2 : 4'h1);
	wire out_step = sck_fall && state_reg == ST_DATA_OUT; // RULE_23
	wire [7:0] pbuf_widx = addr_reg[7:0] + widx_reg;

	always_comb begin
		state_next = state_reg;
		if (cs_rise) begin
			state_next = ST_IDLE; // RULE_17
		end else if (cs_fall) begin
			state_next = ST_OPCODE; // RULE_16
		end else if (phase_end) begin
			case (state_reg)
				ST_OPCODE: state_next = opc_next_st;
				ST_ADDR: state_next = addr_next_st;
				ST_DUMMY: state_next = ST_DATA_OUT;
				ST_DATA_IN: state_next = is_stat_wr ? ST_DONE : ST_DATA_IN;
				default: state_next = state_reg;
			endcase
		end else if (sck_rise && state_reg == ST_DONE) begin
			state_next = ST_IGNORE;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_reg <= 5'h11;
			sync2_reg <= 5'h11;
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {i_cs_b, i_sck, i_sio0, i_sio1, i_wp_b};
			sync2_reg <= sync1_reg;
			sck_prev_reg <= sck_s;
			cs_prev_reg <= cs_b_s;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 6'h00;
			shift_reg <= 32'h0000_0000;
			op_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (cs_fall) cnt_reg <= 6'h00;
			else if (sck_rise && in_phase) cnt_reg <= phase_end ? 6'h00 : cnt_inc;
			if (sck_rise && in_phase) shift_reg <= shift_in;
			if (phase_end && state_reg == ST_OPCODE) op_reg <= shift_in[7:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_reg <= 24'h00_0000;
			byte_cnt_reg <= 9'h000;
			widx_reg <= 8'h00;
			sw_data_reg <= 8'h00;
		end else if (cs_fall) begin
			byte_cnt_reg <= 9'h000;
			widx_reg <= 8'h00;
		end else if (phase_end && state_reg == ST_ADDR) begin
			addr_reg <= shift_in[23:0];
		end else if (phase_end && state_reg == ST_DATA_IN) begin
			sw_data_reg <= shift_in[7:0];
			widx_reg <= widx_reg + 8'h01; // RULE_21
			if (byte_cnt_reg != `SF_PAGE_MAX) byte_cnt_reg <= byte_cnt_reg + 9'h001;
		end
	end

	// page buffer keeps the last 256 bytes, wrapping inside the page
	always_ff @(posedge i_core_clk) begin
		if (phase_end && state_reg == ST_DATA_IN && is_prog) pbuf[pbuf_widx] <= shift_in[7:0]; // RULE_21
		o_pbuf_data <= pbuf[i_pbuf_idx];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_addr <= 24'h00_0000;
			out_reg <= 8'h00;
			out_left_reg <= 4'h0;
			id_idx_reg <= 2'h0;
		end else if (cs_fall) begin
			out_left_reg <= 4'h0;
			id_idx_reg <= 2'h0;
		end else if (phase_end && state_reg == ST_ADDR) begin
			o_rd_addr <= shift_in[23:0];
		end else if (out_step) begin
			out_reg <= dual_out ? {out_word[5:0], 2'b00} : {out_word[6:0], 1'b0};
			out_left_reg <= out_left_next;
			if (out_load) begin
				o_rd_addr <= {o_rd_addr[23:19], o_rd_addr[18:0] + 19'h0_0001};
				id_idx_reg <= (id_idx_reg == 2'h2) ? 2'h0 : id_idx_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sio0 <= 1'b0;
			o_sio1 <= 1'b0;
			o_sio0_oe <= 1'b0;
			o_sio1_oe <= 1'b0;
		end else if (cs_b_s) begin
			o_sio0_oe <= 1'b0;
			o_sio1_oe <= 1'b0;
		end else if (out_step) begin
			o_sio1 <= out_word[7]; // RULE_15 RULE_23
			o_sio0 <= out_word[6]; // RULE_19
			o_sio1_oe <= 1'b1;
			o_sio0_oe <= dual_out;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wel_reg <= 1'b0; // RULE_04
			busy_reg <= 1'b0; // RULE_01
			o_deep_sleep <= 1'b0;
		end else begin
			if (wel_set) wel_reg <= 1'b1;
			else if (wel_clr) wel_reg <= 1'b0; // RULE_04
			if (issue) busy_reg <= 1'b1; // RULE_01
			else if (i_seq_done) busy_reg <= 1'b0;
			if (exec_ok && op_reg == `SF_OPC_SLEEP) o_deep_sleep <= 1'b1;
			else if (wake) o_deep_sleep <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bp_reg <= 3'h0;
			bottom_reg <= 1'b0;
			lock_reg <= 1'b0;
			loaded_reg <= 1'b0;
			o_nv_write <= 1'b0;
			o_nv_value <= `SF_STATUS_RST;
		end else begin
			loaded_reg <= 1'b1;
			o_nv_write <= sw_ok; // RULE_13
			if (!loaded_reg) begin
				bp_reg <= i_nv_status[`SF_ST_LEVEL_HI:`SF_ST_LEVEL_LO]; // RULE_13
				bottom_reg <= i_nv_status[`SF_ST_BOTTOM];
				lock_reg <= i_nv_status[`SF_ST_LOCK];
			end else if (sw_ok) begin
				bp_reg <= sw_data_reg[`SF_ST_LEVEL_HI:`SF_ST_LEVEL_LO]; // RULE_12 RULE_24
				bottom_reg <= sw_data_reg[`SF_ST_BOTTOM];
				lock_reg <= sw_data_reg[`SF_ST_LOCK];
				o_nv_value <= sw_data_reg & 8'hBC;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_op_valid <= 1'b0;
			o_op <= '0;
			o_status <= `SF_STATUS_RST;
		end else begin
			o_op_valid <= issue;
			if (issue) o_op <= '{kind: op_kind, addr: addr_reg, count: byte_cnt_reg};
			o_status <= status_byte; // RULE_01 RULE_03
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence wen_release;
		exec_ok && op_reg == `SF_OPC_WEN;
	endsequence
	sequence sw_free_release;
		exec_ok && is_stat_wr && wel_reg && wp_b_s ##1 1'b1;
	endsequence

	busy_after_issue_a: assert property (o_op_valid |=> o_status[`SF_ST_BUSY]) // RULE_01
		else $error("busy bit not shown after an array operation started");
	busy_only_status_a: assert property ((busy_reg && state_reg == ST_OPCODE && phase_end && // RULE_02
		shift_in[7:0] != `SF_OPC_STAT_RD) |=> state_reg == ST_IGNORE)
		else $error("instruction accepted while busy");
	wel_gates_ops_a: assert property (o_op_valid |-> $past(wel_reg)) // RULE_03
		else $error("array operation issued without write enable");
	wel_cycle_a: assert property (wen_release |=> wel_reg ##1 (!wel_clr or ##1 !wel_reg)) // RULE_04
		else $error("write enable latch not set or cleared as expected");
	wel_autoclear_a: assert property (o_op_valid |-> !wel_reg) // RULE_04
		else $error("write enable latch still set after operation");
	top_region_a: assert property ((!bottom_reg && !bp_reg[2] && bp_reg != 3'h0 && // RULE_06
		&addr_reg[18:16]) |-> target_prot)
		else $error("top region not protected");
	bottom_region_a: assert property ((bottom_reg && !bp_reg[2] && bp_reg != 3'h0 && // RULE_07
		addr_reg[18:16] == 3'h0) |-> target_prot)
		else $error("bottom region not protected");
	level_extremes_a: assert property ((bp_reg[2] |-> target_prot) and // RULE_08
		(bp_reg == 3'h0 |-> !target_prot))
		else $error("full or empty protection decoded wrongly");
	protected_target_a: assert property ((o_op_valid && o_op.kind != OP_CHIP_ERASE) |-> // RULE_09
		!addr_prot(o_op.addr, $past(bp_reg), $past(bottom_reg)))
		else $error("operation issued into protected region");
	chip_erase_guard_a: assert property ((o_op_valid && o_op.kind == OP_CHIP_ERASE) |-> // RULE_10
		$past(bp_reg) == 3'h0)
		else $error("chip erase issued with protection set");
	lock_freeze_a: assert property ((locked && loaded_reg) |=> // RULE_11
		$stable({lock_reg, bottom_reg, bp_reg}))
		else $error("locked protection bits changed");
	free_write_a: assert property (sw_free_release |-> // RULE_12
		bp_reg == $past(sw_data_reg[`SF_ST_LEVEL_HI:`SF_ST_LEVEL_LO], 1) && o_nv_write)
		else $error("status write refused with write-protect pin high");
	reserved_zero_a: assert property (o_status[`SF_ST_RSVD] == 1'b0) // RULE_14
		else $error("reserved status bit reads one");
	abandon_partial_a: assert property ((cs_rise && in_phase && // RULE_17
		cnt_reg != 6'h00) |=> !o_op_valid ##1 !o_op_valid)
		else $error("partial bus cycle was executed");

endmodule : serial_flash_status_protect_decode
`default_nettype wire

// ### verification/serial_flash_status_protect_decode_tb_top.sv
// Purpose: self-checking bench for the flash status and protection decoder
// Assumes: array byte at address a is a[7:0]^5A; sequencer finishes 300 cycles after issue
// Notes: protection cases run as table rows; lock, busy, reads, sleep, abort, reset by hand
`timescale 1ns/1ps
`default_nettype none

module serial_flash_status_protect_decode_tb_top;
	import sf_pkg::*;
	typedef struct packed {
		logic [7:0] st;
		logic [7:0] opc;
		logic [23:0] addr;
		logic go;
	} case_s;
	localparam logic [31:0] IDS = 32'h5C29_E147; // id bytes: values are arbitrary
	logic i_core_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_wp_b = 1'b1;
	logic [7:0] i_rd_data = 8'h00;
	logic i_seq_done = 1'b0;
	logic [7:0] i_pbuf_idx = 8'h00;
	logic [7:0] i_nv_status = 8'h00;
	logic cs_b, sck, mosi, io1, o_sio0, o_sio0_oe, o_sio1, o_sio1_oe, o_op_valid, o_nv_write, o_deep_sleep;
	logic [23:0] o_rd_addr;
	array_op_s o_op;
	logic [7:0] o_pbuf_data, o_nv_value, o_status;
	wire logic sio0 = o_sio0_oe ? o_sio0 : mosi;
	wire logic sio1 = o_sio1_oe ? o_sio1 : io1;
	int compares = 0;
	int miscompares = 0;
	int ops = 0;
	int nv_cnt = 0;
	int seq_cnt = 0;
	int cyc = 0;
	int n_ops, nv0;
	logic chip;
	logic [7:0] rxb [4];
	case_s rows [15] = '{
		'{8'h00, 8'h20, 24'h07F000, 1'b1}, '{8'h04, 8'h20, 24'h070000, 1'b0}, '{8'h04, 8'h20, 24'h06F000, 1'b1},
		'{8'h08, 8'hD8, 24'h060000, 1'b0}, '{8'h0C, 8'hD7, 24'h040000, 1'b0}, '{8'h0C, 8'h20, 24'h03F000, 1'b1},
		'{8'h24, 8'h20, 24'h00F000, 1'b0}, '{8'h24, 8'h20, 24'h010000, 1'b1}, '{8'h28, 8'hD8, 24'h010000, 1'b0},
		'{8'h2C, 8'h20, 24'h03F000, 1'b0}, '{8'h2C, 8'h02, 24'h040000, 1'b1}, '{8'h10, 8'h20, 24'h000000, 1'b0},
		'{8'h14, 8'h02, 24'h07FF00, 1'b0}, '{8'h20, 8'h60, 24'h000000, 1'b1}, '{8'h04, 8'hC7, 24'h000000, 1'b0}};

	serial_flash_status_protect_decode #(.ID_MAKER(IDS[31:24]), .ID_TYPE(IDS[23:16]), .ID_SIZE(IDS[15:8]),
		.ID_PART(IDS[7:0])) serial_flash_status_protect_decode_i (.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck), .i_sio0(sio0), .i_sio1(sio1), .i_wp_b(i_wp_b),
		.o_sio0(o_sio0), .o_sio0_oe(o_sio0_oe), .o_sio1(o_sio1), .o_sio1_oe(o_sio1_oe), .o_rd_addr(o_rd_addr),
		.i_rd_data(i_rd_data), .o_op(o_op), .o_op_valid(o_op_valid), .i_seq_done(i_seq_done),
		.i_pbuf_idx(i_pbuf_idx), .o_pbuf_data(o_pbuf_data), .i_nv_status(i_nv_status), .o_nv_write(o_nv_write),
		.o_nv_value(o_nv_value), .o_status(o_status), .o_deep_sleep(o_deep_sleep));
	spi_master_model spi_master_model_i (.i_core_clk(i_core_clk), .i_miso(sio1), .i_io0(sio0), .o_cs_b(cs_b),
		.o_sck(sck), .o_mosi(mosi), .o_io1(io1));

	initial begin
		forever #50 i_core_clk = ~i_core_clk;
	end
	// array and sequencer stand-ins
	always @(negedge i_core_clk) begin
		i_rd_data <= o_rd_addr[7:0] ^ 8'h5A;
		i_seq_done <= (seq_cnt == 1);
		seq_cnt <= o_op_valid ? 300 : (seq_cnt > 0 ? seq_cnt - 1 : 0);
	end
	always @(posedge i_core_clk) begin
		ops <= ops + int'(o_op_valid === 1'b1);
		nv_cnt <= nv_cnt + int'(o_nv_write === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 45000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t flag got %b want %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t byte got %h want %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t address got %h want %h", $time, got, exp);
		end
	endtask : chk_addr
	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// opcode, then bytes from the top of rest, then reads
	task automatic frame(input logic [7:0] opc, input logic [31:0] rest, input int nrest, input int nrd, input bit dual);
		logic [7:0] r;
		spi_master_model_i.open_frame();
		spi_master_model_i.shift(opc, 8, 1'b0, r);
		for (int k = 0; k < nrest; k++) begin
			spi_master_model_i.shift(rest[31 - 8 * k -: 8], opc == 8'hBB ? 4 : 8, opc == 8'hBB, r);
		end
		for (int k = 0; k < nrd; k++) begin
			spi_master_model_i.shift(8'hFF, dual ? 4 : 8, dual, r);
			rxb[k] = r;
		end
		spi_master_model_i.close_frame();
	endtask : frame
	task automatic put_status(input logic [7:0] st, input logic [7:0] exp);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b1);
		frame(8'h01, {st, 24'h0}, 1, 0, 1'b0);
		chk_byte(o_status, exp);
	endtask : put_status
	task automatic wait_idle;
		for (int t = 0; t < 1000 && o_status[0] !== 1'b0; t++) @(negedge i_core_clk);
		chk_bit(o_status[0], 1'b0);
	endtask : wait_idle

	initial begin
		repeat (5) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		repeat (5) @(negedge i_core_clk);
		chk_byte(o_status, 8'h00);
		foreach (rows[n]) begin
			put_status(rows[n].st, rows[n].st);
			chk_byte(o_nv_value, rows[n].st);
			frame(8'h06, 32'h0, 0, 0, 1'b0);
			n_ops = ops;
			chip = (rows[n].opc == 8'h60) || (rows[n].opc == 8'hC7);
			frame(rows[n].opc, {rows[n].addr, 8'h3C}, chip ? 0 : (rows[n].opc == 8'h02 ? 4 : 3), 0, 1'b0);
			chk_bit(ops != n_ops, rows[n].go);
			chk_bit(o_status[1], 1'b0);
			if (rows[n].go) begin
				chk_bit(o_status[0], 1'b1);
				chk_byte({6'h00, o_op.kind}, rows[n].opc == 8'h02 ? 8'h03 : chip ? 8'h02 : {7'h00, rows[n].opc == 8'hD8});
				if (!chip) chk_addr(o_op.addr, rows[n].addr);
				if (rows[n].opc == 8'h02) chk_addr({15'h0, o_op.count}, 24'h000001);
				if (rows[n].opc == 8'h02) chk_byte(o_pbuf_data, 8'h3C);
				wait_idle();
			end
		end
		$display("test protection table done");
		put_status(8'h84, 8'h84);
		i_wp_b = 1'b0;
		nv0 = nv_cnt;
		put_status(8'h00, 8'h84);
		chk_bit(nv_cnt == nv0, 1'b1);
		i_wp_b = 1'b1;
		put_status(8'h40, 8'h00);
		chk_byte(o_nv_value, 8'h00);
		$display("test lock done");
		frame(8'h20, 32'h0, 3, 0, 1'b0);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		frame(8'h04, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b0);
		n_ops = ops;
		frame(8'hD8, 32'h0, 3, 0, 1'b0);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		spi_master_model_i.open_frame();
		spi_master_model_i.shift(8'h20, 8, 1'b0, rxb[3]);
		spi_master_model_i.shift(8'h00, 5, 1'b0, rxb[3]);
		spi_master_model_i.close_frame();
		chk_bit(ops == n_ops, 1'b1);
		$display("test refusals done");
		put_status(8'h00, 8'h00);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		frame(8'h20, 32'h0, 3, 0, 1'b0);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b0);
		frame(8'h05, 32'h0, 0, 1, 1'b0);
		chk_byte(rxb[0], 8'h01);
		wait_idle();
		$display("test busy done");
		frame(8'h03, {24'h07FFFF, 8'h0}, 3, 2, 1'b0);
		chk_byte(rxb[0], 8'hA5);
		chk_byte(rxb[1], 8'h5A);
		chk_addr(o_rd_addr, 24'h000002);
		frame(8'h0B, {24'h000010, 8'h0}, 4, 1, 1'b0);
		chk_byte(rxb[0], 8'h4A);
		frame(8'h3B, {24'h000020, 8'h0}, 4, 1, 1'b1);
		chk_byte(rxb[0], 8'h7A);
		frame(8'hBB, {24'h000030, 8'h0}, 4, 1, 1'b1);
		chk_byte(rxb[0], 8'h6A);
		frame(8'h9F, 32'h0, 0, 4, 1'b0);
		chk_byte(rxb[0], IDS[31:24]);
		chk_byte(rxb[1], IDS[23:16]);
		chk_byte(rxb[2], IDS[15:8]);
		chk_byte(rxb[3], IDS[31:24]);
		frame(8'hAB, 32'h0, 3, 1, 1'b0);
		chk_byte(rxb[0], IDS[7:0]);
		$display("test reads done");
		spi_master_model_i.set_mode(1'b1);
		frame(8'h03, {24'h000041, 8'h0}, 3, 1, 1'b0);
		chk_byte(rxb[0], 8'h1B);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b1);
		frame(8'h04, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b0);
		spi_master_model_i.set_mode(1'b0);
		$display("test clock idle high done");
		frame(8'hB9, 32'h0, 0, 0, 1'b0);
		chk_bit(o_deep_sleep, 1'b1);
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		chk_bit(o_status[1], 1'b0);
		frame(8'hAB, 32'h0, 0, 0, 1'b0);
		chk_bit(o_deep_sleep, 1'b0);
		$display("test sleep done");
		frame(8'h06, 32'h0, 0, 0, 1'b0);
		i_rst_b = 1'b0;
		i_nv_status = 8'h2C;
		repeat (3) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		repeat (5) @(negedge i_core_clk);
		chk_byte(o_status, 8'h2C);
		$display("test reset done");
		close_out();
	end
endmodule : serial_flash_status_protect_decode_tb_top
`default_nettype wire

// ### verification/spi_master_model.sv
// Purpose: serial bus master facing the flash decoder's link pins
// Assumes: i_core_clk is 10 MHz; link clock half period is 4 core cycles (800 ns period)
// Notes: tasks called by the bench; clock idle level chosen by set_mode; data sampled late in the high phase
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
	// clock
	input wire logic i_core_clk,
	// resolved data lines
	input wire logic i_miso,
	input wire logic i_io0,
	// driven link pins
	output var logic o_cs_b,
	output var logic o_sck,
	output var logic o_mosi,
	output var logic o_io1
);
	bit idle_hi = 1'b0;
	initial begin
		o_cs_b = 1'b1;
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_io1 = 1'b1;
	end

	task automatic open_frame;
		@(negedge i_core_clk);
		o_cs_b = 1'b0;
		repeat (4) @(negedge i_core_clk);
	endtask : open_frame

	// dual clocks carry two bits: io1 the higher one
	task automatic shift(input logic [7:0] tx, input int clocks, input bit dual, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < clocks; i++) begin
			if (idle_hi) o_sck = 1'b0;
			if (dual) begin
				o_io1 = tx[7 - 2 * i];
				o_mosi = tx[6 - 2 * i];
			end else begin
				o_mosi = tx[7 - i];
				o_io1 = ~o_io1;
			end
			repeat (4) @(negedge i_core_clk);
			o_sck = 1'b1;
			repeat (3) @(negedge i_core_clk);
			rx = dual ? {rx[5:0], i_miso, i_io0} : {rx[6:0], i_miso};
			@(negedge i_core_clk);
			if (!idle_hi) o_sck = 1'b0;
		end
	endtask : shift

	// clock idle level between frames: low or high
	task automatic set_mode(input bit hi);
		@(negedge i_core_clk);
		idle_hi = hi;
		o_sck = hi;
		repeat (4) @(negedge i_core_clk);
	endtask : set_mode

	// released line shows the inverse so a stale value cannot pass
	task automatic close_frame;
		@(negedge i_core_clk);
		o_cs_b = 1'b1;
		o_mosi = ~o_mosi;
		repeat (6) @(negedge i_core_clk);
	endtask : close_frame
endmodule : spi_master_model
`default_nettype wire
